// ---- hw/rzc_device.sv ----
// Cascaded driver end: decodes frames, keeps its own, reshapes the rest, drives PWM
`timescale 1ns/1ps
`include "rzc_map.svh"
module rzc_device (
  input  wire logic   i_core_clk,        // 125 MHz core clock
  input  wire logic   i_reset_n,         // Synchronous reset, active low
  rzc_link_if.device  link,              // Serial link
  output logic        o_red_pwm_out,     // Red PWM output
  output logic        o_green_pwm_out,   // Green PWM output
  output logic        o_blue_pwm_out,    // Blue PWM output
  output logic        o_frame_held       // Own frame captured since last reset code
);
  localparam int SMP = `RZC_SAMPLE_CYC;
  localparam int RST = `RZC_RST_DET_CYC;
  localparam int IDL = `RZC_IDLE_CYC;
  localparam int LAT = `RZC_LAT_CYC;
  localparam int SHT = `RZC_SHORT_CYC;
  localparam int LNG = `RZC_LONG_CYC;
  localparam int STP = `RZC_PWM_STEP_CYC;
  // Input register, edge detect, start and output register take 4 cycles of the delay
  localparam int LAT_WAIT = LAT - 4;

  logic              prim_q;         // Registered primary line
  logic              back_q;         // Registered backup line
  logic              use_back_q;     // Selected source is the backup line
  logic [8:0]        prim_idle_q;    // Cycles since primary last moved
  logic [8:0]        back_idle_q;    // Cycles since backup last moved
  logic              line_q;         // Selected line, one cycle late
  logic              line;           // Selected line
  logic [7:0]        bit_cnt_q;      // Cycles since rising edge
  logic              in_bit_q;       // Between rise and sample point
  logic [12:0]       low_cnt_q;      // Cycles the line has been low
  logic              rst_seen_q;     // Reset code in progress
  logic [4:0]        nbits_q;        // Bits captured into own frame
  logic [23:0]       shift_q;        // Frame being assembled
  rzc_pkg::rzc_frame_t latched_q;    // Frame shown on the PWM outputs
  logic              fwd_q;          // Forwarding enabled
  logic              bit_ready;      // Decoded bit valid this cycle
  logic              bit_val;        // Decoded bit value
  logic [7:0]        lat_cnt_q;      // Delay before a reshaped bit starts
  logic              lat_pend_q;     // Reshaped bit waiting to start
  logic [7:0]        tx_cnt_q;       // Position inside the outgoing bit
  logic              tx_busy_q;      // Outgoing bit in progress
  logic              tx_val_q;       // Value of outgoing bit
  logic [13:0]       step_q;         // Prescaler for PWM steps
  logic [7:0]        phase_q;        // PWM phase, 256 steps per period

  // Primary is idle once it has not toggled for a few bit times
  // Backup is taken only once it moves while primary is idle; a backup dead low never hides a live primary, but one stuck high stays selected
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      prim_q      <= 1'b0;
      back_q      <= 1'b0;
      prim_idle_q <= '0;
      back_idle_q <= '0;
      use_back_q  <= 1'b0;
    end
    else
    begin
      prim_q <= link.serial_in;
      back_q <= link.serial_in_backup;
      if (link.serial_in != prim_q)
        prim_idle_q <= '0;
      else if (prim_idle_q != 9'(IDL))
        prim_idle_q <= prim_idle_q + 9'h001;
      // Backup activity measured on its own line, not on the selected one
      if (link.serial_in_backup != back_q)
        back_idle_q <= '0;
      else if (back_idle_q != 9'(IDL))
        back_idle_q <= back_idle_q + 9'h001;
      // Only switch while both are low so a bit is never cut in half
      if (!prim_q && !back_q)
        use_back_q <= (prim_idle_q == 9'(IDL)) && (back_idle_q != 9'(IDL));
    end
  end

  assign line = use_back_q ? back_q : prim_q;

  // Bit decoding by sampling a fixed time after the rising edge
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      line_q    <= 1'b0;
      bit_cnt_q <= '0;
      in_bit_q  <= 1'b0;
      low_cnt_q <= '0;
      rst_seen_q <= 1'b0;
    end
    else
    begin
      line_q <= line;
      if (line && !line_q)
      begin
        bit_cnt_q <= 8'h01;
        in_bit_q  <= 1'b1;
      end
      else if (in_bit_q)
      begin
        bit_cnt_q <= bit_cnt_q + 8'h01;
        if (bit_cnt_q == 8'(SMP))
          in_bit_q <= 1'b0;
      end
      // Low-time counter saturates; the code ends on the next rise
      if (line)
        low_cnt_q <= '0;
      else if (low_cnt_q != 13'(RST))
        low_cnt_q <= low_cnt_q + 13'h0001;
      if (low_cnt_q == 13'(RST - 1) && !line)
        rst_seen_q <= 1'b1;
      else if (line)
        rst_seen_q <= 1'b0;
    end
  end

  // High past 0.6 us is a one, else a zero
  assign bit_ready = in_bit_q && (bit_cnt_q == 8'(SMP));
  assign bit_val   = line;

  // Own-frame capture and latch on reset code
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      nbits_q   <= '0;
      shift_q   <= '0;
      fwd_q     <= 1'b0;
      latched_q <= '0;
    end
    else if (low_cnt_q == 13'(RST - 1) && !line && !rst_seen_q)
    begin
      latched_q <= shift_q;
      nbits_q   <= '0;
      fwd_q     <= 1'b0;
    end
    else if (bit_ready)
    begin
      if (nbits_q != 5'(`RZC_FRAME_BITS))
      begin
        shift_q <= {shift_q[22:0], bit_val};
        nbits_q <= nbits_q + 5'h01;
        if (nbits_q == 5'(`RZC_FRAME_BITS - 1))
          fwd_q <= 1'b1;
      end
    end
  end

  // Forwarded bit starts high before its value is known; the sample only picks the
  // high length, which keeps the delay near 0.4 us instead of past the 0.6 us sample
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      lat_pend_q <= 1'b0;
      lat_cnt_q  <= '0;
      tx_busy_q  <= 1'b0;
      tx_cnt_q   <= '0;
      tx_val_q   <= 1'b0;
    end
    else
    begin
      // Bit end first, so a start in the same cycle wins
      if (tx_busy_q)
      begin
        if (tx_cnt_q == 8'(`RZC_BIT_CYC - 1))
          tx_busy_q <= 1'b0;
        else
          tx_cnt_q <= tx_cnt_q + 8'h01;
      end
      if (line && !line_q && fwd_q)
      begin
        lat_pend_q <= 1'b1;
        lat_cnt_q  <= 8'(LAT_WAIT);
      end
      else if (lat_pend_q && lat_cnt_q != 8'h00)
        lat_cnt_q <= lat_cnt_q - 8'h01;
      // Restart on the last cycle of the previous bit so back-to-back bits never slip
      else if (lat_pend_q && (!tx_busy_q || tx_cnt_q == 8'(`RZC_BIT_CYC - 1)))
      begin
        lat_pend_q <= 1'b0;
        tx_busy_q  <= 1'b1;
        tx_val_q   <= 1'b0;
        tx_cnt_q   <= '0;
      end
      // Value arrives well inside the shortest high phase
      if (bit_ready && fwd_q)
        tx_val_q <= bit_val;
    end
  end

  // Serial output low unless a reshaped bit is in its high phase
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      link.serial_out <= 1'b0;
    else
      link.serial_out <= tx_busy_q && (tx_cnt_q < (tx_val_q ? 8'(LNG) : 8'(SHT)));
  end

  // PWM phase: 256 steps of a 4 ms period
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      step_q  <= '0;
      phase_q <= '0;
    end
    else if (step_q == 14'(STP - 1))
    begin
      step_q  <= '0;
      phase_q <= phase_q + 8'h01;
    end
    else
      step_q <= step_q + 14'h0001;
  end

  // Channel is on while phase is below its value; zero never lights
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      o_red_pwm_out   <= 1'b0;
      o_green_pwm_out <= 1'b0;
      o_blue_pwm_out  <= 1'b0;
      o_frame_held    <= 1'b0;
    end
    else
    begin
      o_red_pwm_out   <= phase_q < latched_q[`RZC_RED_MSB -: 8];
      o_green_pwm_out <= phase_q < latched_q[`RZC_GRN_MSB -: 8];
      o_blue_pwm_out  <= phase_q < latched_q[`RZC_BLU_MSB -: 8];
      o_frame_held    <= fwd_q;
    end
  end
endmodule : rzc_device

// ---- inc/rzc_map.svh ----
// Timing and frame constants for the RZ cascade RGB PWM link
`ifndef RZC_MAP_SVH
`define RZC_MAP_SVH
`define RZC_CLK_NS          8
`define RZC_BIT_SHORT_NS    300
`define RZC_BIT_LONG_NS     900
`define RZC_SAMPLE_NS       600
`define RZC_RST_DET_NS      24000
`define RZC_RST_SEND_NS     80000
`define RZC_PWM_PERIOD_NS   4000000
`define RZC_LAT_NS          400
`define RZC_IDLE_NS         3000
`define RZC_SHORT_CYC       (`RZC_BIT_SHORT_NS / `RZC_CLK_NS)
`define RZC_LONG_CYC        (`RZC_BIT_LONG_NS / `RZC_CLK_NS)
`define RZC_BIT_CYC         (`RZC_SHORT_CYC + `RZC_LONG_CYC)
`define RZC_SAMPLE_CYC      (`RZC_SAMPLE_NS / `RZC_CLK_NS)
`define RZC_RST_DET_CYC     ((`RZC_RST_DET_NS + `RZC_CLK_NS - 1) / `RZC_CLK_NS + 1)
`define RZC_RST_SEND_CYC    ((`RZC_RST_SEND_NS + `RZC_CLK_NS - 1) / `RZC_CLK_NS)
`define RZC_PWM_STEP_CYC    (`RZC_PWM_PERIOD_NS / `RZC_CLK_NS / 256)
`define RZC_LAT_CYC         (`RZC_LAT_NS / `RZC_CLK_NS)
`define RZC_IDLE_CYC        ((`RZC_IDLE_NS + `RZC_CLK_NS - 1) / `RZC_CLK_NS)
`define RZC_FRAME_BITS      24
`define RZC_RED_MSB         23
`define RZC_GRN_MSB         15
`define RZC_BLU_MSB         7
`endif

// ---- inc/rzc_pkg.sv ----
// Types shared by both ends of the RZ cascade link
package rzc_pkg;
  typedef logic [23:0] rzc_frame_t;   // Red, green, blue bytes, red in the top byte
  typedef enum logic [2:0] {
    RZC_TX_IDLE = 3'b001,
    RZC_TX_BITS = 3'b010,
    RZC_TX_RST  = 3'b100
  } rzc_tx_state_e;
endpackage : rzc_pkg

// ---- inc/rzc_link_if.sv ----
// Single-wire link between the upstream sender and one cascaded driver
`timescale 1ns/1ps
interface rzc_link_if;
  logic serial_in;          // Primary line, sender to device
  logic serial_in_backup;   // Redundant line from two stages upstream
  logic serial_out;         // Reshaped stream to the next device
  modport host   (output serial_in, output serial_in_backup, input serial_out);
  modport device (input serial_in, input serial_in_backup, output serial_out);
endinterface : rzc_link_if

// ---- hw/rzc_host.sv ----
// Upstream sender end: streams frames MSB first, then a reset code
`timescale 1ns/1ps
`include "rzc_map.svh"
module rzc_host (
  input  wire logic          i_core_clk,     // 125 MHz core clock
  input  wire logic          i_reset_n,      // Synchronous reset, active low
  input  wire logic          i_frame_valid,  // Frame offered
  input  wire logic [23:0]   i_frame,        // Red, green, blue bytes
  input  wire logic          i_last,         // Frame is last of the chain
  output logic               o_frame_ready,  // Frame taken this cycle
  output logic               o_busy,         // Sending bits or reset code
  rzc_link_if.host           link            // Serial link
);
  rzc_pkg::rzc_tx_state_e state_q;   // Sender state
  logic [23:0]  sh_q;                // Bits left to send
  logic [4:0]   nb_q;                // Bits left in the frame
  logic [7:0]   cyc_q;               // Position inside bit
  logic [13:0]  rst_q;               // Reset code counter
  logic         last_q;              // Reset code follows this frame

  // Bits sent with exact high/low phases; reset code after the last frame
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      state_q        <= rzc_pkg::RZC_TX_IDLE;
      sh_q           <= '0;
      nb_q           <= '0;
      cyc_q          <= '0;
      rst_q          <= '0;
      last_q         <= 1'b0;
      o_frame_ready  <= 1'b0;
      o_busy         <= 1'b0;
      link.serial_in <= 1'b0;
    end
    else
    begin
      o_frame_ready <= 1'b0;
      case (state_q)
        rzc_pkg::RZC_TX_IDLE:
        begin
          link.serial_in <= 1'b0;
          o_busy         <= 1'b0;
          if (i_frame_valid && !o_frame_ready)
          begin
            sh_q          <= i_frame;
            last_q        <= i_last;
            nb_q          <= 5'(`RZC_FRAME_BITS);
            cyc_q         <= '0;
            o_frame_ready <= 1'b1;
            o_busy        <= 1'b1;
            state_q       <= rzc_pkg::RZC_TX_BITS;
          end
        end
        rzc_pkg::RZC_TX_BITS:
        begin
          link.serial_in <= cyc_q < (sh_q[23] ? 8'(`RZC_LONG_CYC) : 8'(`RZC_SHORT_CYC));
          if (cyc_q == 8'(`RZC_BIT_CYC - 1))
          begin
            cyc_q <= '0;
            sh_q  <= {sh_q[22:0], 1'b0};
            nb_q  <= nb_q - 5'h01;
            if (nb_q == 5'h01)
            begin
              rst_q   <= '0;
              state_q <= last_q ? rzc_pkg::RZC_TX_RST : rzc_pkg::RZC_TX_IDLE;
            end
          end
          else
            cyc_q <= cyc_q + 8'h01;
        end
        rzc_pkg::RZC_TX_RST:
        begin
          link.serial_in <= 1'b0;
          if (rst_q == 14'(`RZC_RST_SEND_CYC - 1))
            state_q <= rzc_pkg::RZC_TX_IDLE;
          else
            rst_q <= rst_q + 14'h0001;
        end
        default:
          state_q <= rzc_pkg::RZC_TX_IDLE;
      endcase
    end
  end

  // Backup line idle: a sender has no stage two upstream
  always_ff @(posedge i_core_clk)
  begin
    link.serial_in_backup <= 1'b0;
  end
endmodule : rzc_host

// ---- testbench/rzc_link_asserts.sv ----
// Checker for the single-wire link lines
`timescale 1ns/1ps
`include "rzc_map.svh"
module rzc_link_asserts (
  input  wire logic i_core_clk,        // Core clock
  input  wire logic i_reset_n,         // Sync reset, active low
  input  wire logic serial_in,         // Primary line
  input  wire logic serial_in_backup,  // Redundant line
  input  wire logic serial_out         // Reshaped output
);
  logic [15:0] hin_q;   // High length, input
  logic [15:0] hout_q;  // High length, output
  logic [15:0] lo_q;    // Low length, input
  logic [15:0] gin_q;   // Cycles since input rise
  logic [15:0] gout_q;  // Cycles since output rise
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // Gap counters saturate so a long idle never wraps into a false short gap
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      {hin_q, hout_q, lo_q} <= '0;
      {gin_q, gout_q} <= '1;
    end
    else
    begin
      hin_q  <= serial_in ? hin_q + 16'h1 : 16'h0;
      hout_q <= serial_out ? hout_q + 16'h1 : 16'h0;
      lo_q   <= serial_in ? 16'h0 : lo_q + {15'h0, ~&lo_q};
      gin_q  <= $rose(serial_in) ? 16'h1 : gin_q + {15'h0, ~&gin_q};
      gout_q <= $rose(serial_out) ? 16'h1 : gout_q + {15'h0, ~&gout_q};
    end
  end
  property p_rst_quiet; $rose(i_reset_n) |-> !serial_out [*8]; endproperty
  property p_bkp; !serial_in_backup; endproperty
  property p_in_hi; $fell(serial_in) |-> hin_q inside {`RZC_SHORT_CYC, `RZC_LONG_CYC}; endproperty
  property p_out_hi; $fell(serial_out) |-> hout_q inside {`RZC_SHORT_CYC, `RZC_LONG_CYC}; endproperty
  property p_in_rz; $fell(serial_in) |=> !serial_in [*8]; endproperty
  property p_out_rate; $rose(serial_out) |-> gout_q >= `RZC_BIT_CYC; endproperty
  property p_lat; $rose(serial_out) |-> gin_q inside {[48:52]}; endproperty
  property p_quiet; lo_q >= 16'd1000 |-> !serial_out; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("output active after reset");
  a_bkp: assert property (p_bkp) else $error("backup line not idle");
  a_in_hi: assert property (p_in_hi) else $error("input high phase length wrong");
  a_out_hi: assert property (p_out_hi) else $error("output high phase length wrong");
  a_in_rz: assert property (p_in_rz) else $error("input low phase too short");
  a_out_rate: assert property (p_out_rate) else $error("output bits too close");
  a_lat: assert property (p_lat) else $error("forward latency out of range");
  a_quiet: assert property (p_quiet) else $error("output active in reset code");
  c_out_bit: cover property ($rose(serial_out));
  c_one_bit: cover property ($fell(serial_in) && hin_q == `RZC_LONG_CYC);
  c_rst_code: cover property (lo_q == 16'd3002);
endmodule : rzc_link_asserts

// ---- testbench/test_rz_cascade_rgb_pwm_driver.sv ----
// Bench: host end drives device end across the link
`timescale 1ns/1ps
module test_rz_cascade_rgb_pwm_driver;
  logic        clk = 1'b0;    // Core clock
  logic        rst_n = 1'b0;  // Sync reset, active low
  logic        vld = 1'b0;    // Frame offered
  logic [23:0] frm = 24'h0;   // Frame to send
  logic        lst = 1'b0;    // Last frame of chain
  logic        rdy, bsy, red, grn, blu, held;  // Design outputs
  logic [47:0] in_sh = '0;    // Bits seen on the input line
  logic [47:0] out_sh = '0;   // Bits seen on the output line
  int          in_hi, out_hi, n_out, failures, num_checks;
  rzc_link_if link ();
  rzc_host i_rzc_host (.i_core_clk(clk), .i_reset_n(rst_n), .i_frame_valid(vld), .i_frame(frm),
    .i_last(lst), .o_frame_ready(rdy), .o_busy(bsy), .link(link));
  rzc_device i_rzc_device (.i_core_clk(clk), .i_reset_n(rst_n), .link(link), .o_red_pwm_out(red),
    .o_green_pwm_out(grn), .o_blue_pwm_out(blu), .o_frame_held(held));
  rzc_link_asserts i_rzc_link_asserts (.i_core_clk(clk), .i_reset_n(rst_n), .serial_in(link.serial_in),
    .serial_in_backup(link.serial_in_backup), .serial_out(link.serial_out));
  initial forever #4 clk = ~clk;
  // Decode both lines by high length; over 75 cycles is a one
  always @(posedge clk)
  begin
    if (link.serial_in) in_hi++;
    else if (in_hi > 0)
    begin
      in_sh = {in_sh[46:0], in_hi > 75};
      in_hi = 0;
    end
    if (link.serial_out) out_hi++;
    else if (out_hi > 0)
    begin
      out_sh = {out_sh[46:0], out_hi > 75};
      out_hi = 0;
      n_out++;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Offer a frame, hold it until taken, then wait out bits and reset code
  task send(input logic [23:0] f, input logic l);
    int n;
    n = 0;
    @(posedge clk); #1;
    vld = 1'b1; frm = f; lst = l;
    do begin @(posedge clk); #1; n++; end while (rdy !== 1'b1 && n < 10);
    vld = 1'b0;
    chk(rdy, 1);
    while (bsy === 1'b1 && n < 20000) begin @(posedge clk); #1; n++; end
    chk(bsy, 0);
    repeat (2) @(posedge clk);
  endtask : send
  // Window is far shorter than the PWM period, so each channel is only judged as on or off for most of the window
  task pwm(output int r, output int g, output int b);
    r = 0;
    g = 0;
    b = 0;
    repeat (4000) begin @(posedge clk); #1; r += red; g += grn; b += blu; end
  endtask : pwm
  task t_capture;
    send(24'hFF005A, 1'b0);
    chk(in_sh[23:0], 24'hFF005A);
    chk(held, 1);
    chk(n_out, 0);
    chk({red, grn, blu}, 0);
    $display("test capture done");
  endtask : t_capture
  task t_forward;
    int r, g, b;
    send(24'hA5C381, 1'b1);
    chk(n_out, 24);
    chk(out_sh[23:0], 24'hA5C381);
    chk(held, 0);
    pwm(r, g, b);
    chk(r >= 2047, 1);
    chk(g, 0);
    chk(b >= 2047, 1);
    $display("test forward done");
  endtask : t_forward
  task t_recapture;
    int r, g, b;
    send(24'h00FF00, 1'b1);
    chk(n_out, 24);
    chk(held, 0);
    pwm(r, g, b);
    chk(r, 0);
    chk(g >= 2047, 1);
    chk(b, 0);
    $display("test recapture done");
  endtask : t_recapture
  task stop_test;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    chk({held, red, grn, blu, link.serial_out}, 0);
    t_capture;
    t_forward;
    t_recapture;
    stop_test;
  end
  // Run needs about 40k cycles; twice that means a hang
  initial
  begin
    repeat (80000) @(posedge clk);
    failures++;
    stop_test;
  end
endmodule : test_rz_cascade_rgb_pwm_driver
